// file: lcd_regs.svh
/*
 Constants for the display controller host register logic: field positions,
 reset values and timing counts. Assumes a 250 MHz core clock.
*/
`ifndef LCD_REGS_SVH
`define LCD_REGS_SVH

// ----------------------------------------------------------------
// Register widths and memory geometry
// ----------------------------------------------------------------
`define REG_W 8
`define DISP_DEPTH 16
`define GLYPH_DEPTH 32
`define ICON_DEPTH 16
`define GLYPH_W 5
`define ICON_W 5
`define ADDR_W 5

// ----------------------------------------------------------------
// Command codes and fields
// ----------------------------------------------------------------
`define CMD_CLEAR 8'h01
`define CMD_HOME 8'h02
`define CMD_MODE_HI 6'h01
`define CMD_MODE_DEC_BIT 1
`define CMD_SET_DISP_HI 4'h8
`define CMD_SET_GLYPH_HI 3'h2
`define CMD_SET_ICON_HI 4'h3
`define BUSY_BIT 7

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define OUT_LATCH_RST 8'hff
`define REQ_LATCH_RST 8'h00
`define RESET_MIN_NS 1800
`define CLK_PERIOD_NS 4
`define RESET_MIN_CYC ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SHIFT_MAX_KHZ 1000
`define BUSY_CYC 4
`define COM_COUNT 18
`define SCAN_DIV 256

`endif

// file: lcd_pkg.sv
/*
 Types shared by the display controller register logic.
 Assumes the constants header is compiled alongside.
*/
package lcd_pkg;

   // ----------------------------------------------------------------
   // Memory target and register selection
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MEM_DISP,
      MEM_GLYPH,
      MEM_ICON
   } mem_sel_t;

   typedef struct packed {
      logic test_sel;
      logic reg_sel;
      logic dir_sel;
   } select_t;

   typedef struct packed {
      logic [7:0] data;
      select_t sel;
   } frame_t;

endpackage

// file: lcd_serial_slave.sv
/*
 Serial frame receiver/transmitter for the host link. Samples the shift
 clock, chip select and data with the core clock; assumes the link runs
 well below a quarter of the core rate.
*/
`timescale 1ns/100ps
`include "lcd_regs.svh"

module lcd_serial_slave (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic serial_clock,
   input wire logic chip_select_n,
   input wire logic serial_data_in,
   input wire logic [7:0] tx_byte,
   output logic serial_data_out,
   output logic serial_data_oe,
   output logic frame_start,
   output logic frame_done,
   output logic [7:0] rx_byte
);

   // ----------------------------------------------------------------
   // Two-flop synchronisers
   // ----------------------------------------------------------------
   logic [2:0] meta_q;
   logic [2:0] sync_q;
   logic sclk_prev_q;
   logic cs_prev_q;
   logic [7:0] shift_q;
   logic [2:0] count_q;

   // First stage read only by second stage; three core cycles of lag stay far
   // inside a shift half period at the link's top rate
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 3'h3;
         sync_q <= 3'h3;
      end else begin
         meta_q <= {serial_clock, chip_select_n, serial_data_in};
         sync_q <= meta_q;
      end
   end

   wire logic sclk_s = sync_q[2];
   wire logic cs_n_s = sync_q[1];
   wire logic sdi_s = sync_q[0];
   wire logic rise = sclk_s & ~sclk_prev_q;
   wire logic fall = ~sclk_s & sclk_prev_q;

   // Edge history
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_prev_q <= 1'b1;
         cs_prev_q <= 1'b1;
      end else begin
         sclk_prev_q <= sclk_s;
         cs_prev_q <= cs_n_s;
      end
   end

   assign frame_start = ~cs_n_s & cs_prev_q;

   // Shift MSB first: sample on rise, next bit presented on fall
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_q <= 8'h00;
         count_q <= 3'h0;
         frame_done <= 1'b0;
         rx_byte <= 8'h00;
      end else begin
         frame_done <= 1'b0;
         if (frame_start) begin
            shift_q <= tx_byte;
            count_q <= 3'h0;
         end else if (!cs_n_s && rise) begin
            shift_q <= {shift_q[6:0], sdi_s};
            count_q <= count_q + 3'h1;
            if (count_q == 3'h7) begin
               frame_done <= 1'b1;
               rx_byte <= {shift_q[6:0], sdi_s};
            end
         end
      end
   end

   // Read data output, refreshed after each falling edge
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         serial_data_out <= 1'b0;
      end else if (frame_start) begin
         serial_data_out <= tx_byte[7];
      end else if (!cs_n_s && fall) begin
         serial_data_out <= shift_q[7];
      end
   end

   assign serial_data_oe = 1'b0;

endmodule

// file: lcd_host_regs.sv
/*
 Host register access of a single-line dot-matrix display controller with
 key scan. Assumes the host drives an 8-bit serial frame per access with the
 select lines steady for the frame, and polls busy between writes.
*/
`timescale 1ns/100ps
`include "lcd_regs.svh"

module lcd_host_regs (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic test_select,
   input wire logic register_select,
   input wire logic direction_select,
   input wire logic chip_select_n,
   input wire logic serial_clock,
   input wire logic serial_data_in,
   output logic serial_data_out,
   output logic serial_data_oe,
   input wire logic [3:0] key_return_lines,
   output logic [7:0] key_drive_lines,
   input wire logic [7:0] input_pins,
   output logic [5:0] output_pins_oe,
   output logic key_pressed_flag,
   output logic [4:0] common_index,
   output logic [7:0] cursor_char
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [15:0] pin_meta_q;
   logic [15:0] pin_sync_q;

   // First stage read only by second stage; idle levels at reset avoid a false key
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_q <= 16'h8f00;
         pin_sync_q <= 16'h8f00;
      end else begin
         pin_meta_q <= {chip_select_n, test_select, register_select, direction_select,
                        key_return_lines, input_pins};
         pin_sync_q <= pin_meta_q;
      end
   end

   lcd_pkg::select_t sel;
   assign sel = lcd_pkg::select_t'(pin_sync_q[14:12]);
   wire logic [3:0] key_ret_s = pin_sync_q[11:8];
   wire logic [7:0] in_pins_s = pin_sync_q[7:0];
   wire logic cs_n_s = pin_sync_q[15];

   // ----------------------------------------------------------------
   // Registers and memories
   // ----------------------------------------------------------------
   logic [`REG_W-1:0] command_q;
   logic [`REG_W-1:0] data_q;
   logic [`REG_W-1:0] key_q;
   logic [`REG_W-1:0] latch_q;
   logic [`REG_W-1:0] in_port_q;
   logic [`ADDR_W-1:0] ptr_q;
   lcd_pkg::mem_sel_t target_q;
   logic decrement_q;
   logic [2:0] busy_q;
   logic pend_write_q;
   logic pend_read_q;
   logic fetch_q;
   logic [7:0] disp_mem_q [`DISP_DEPTH];
   logic [`GLYPH_W-1:0] glyph_mem_q [`GLYPH_DEPTH];
   logic [`ICON_W-1:0] icon_mem_q [`ICON_DEPTH];

   logic [7:0] tx_byte;
   logic frame_start;
   logic frame_done;
   logic [7:0] rx_byte;

   lcd_serial_slave u_link (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .serial_clock(serial_clock),
      .chip_select_n(chip_select_n),
      .serial_data_in(serial_data_in),
      .tx_byte(tx_byte),
      .serial_data_out(serial_data_out),
      .serial_data_oe(),
      .frame_start(frame_start),
      .frame_done(frame_done),
      .rx_byte(rx_byte)
   );

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   function automatic logic is_sel(input lcd_pkg::select_t s, input logic [2:0] code);
      is_sel = ({s.test_sel, s.reg_sel, s.dir_sel} == code);
   endfunction

   wire logic wr_cmd = frame_done & is_sel(sel, 3'b000);
   wire logic wr_data = frame_done & is_sel(sel, 3'b010);
   wire logic rd_mem = frame_done & is_sel(sel, 3'b111);
   wire logic busy = (busy_q != 3'h0) | pend_write_q | pend_read_q;

   // Read data mux, captured at frame start; command register has no path
   always_comb begin
      tx_byte = 8'h00;
      if (is_sel(sel, 3'b001)) begin
         tx_byte = in_port_q;
      end else if (is_sel(sel, 3'b011)) begin
         tx_byte = key_q;
      end else if (is_sel(sel, 3'b101)) begin
         tx_byte = {busy, 2'b00, ptr_q};
      end else if (is_sel(sel, 3'b111)) begin
         tx_byte = data_q;
      end
   end

   // Driving SERIAL_DATA_IO only during read frames keeps the host free to drive writes
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         serial_data_oe <= 1'b0;
      end else if (cs_n_s) begin
         serial_data_oe <= 1'b0;
      end else if (frame_start) begin
         serial_data_oe <= sel.dir_sel & ~is_sel(sel, 3'b001) | is_sel(sel, 3'b001);
      end
   end

   // ----------------------------------------------------------------
   // Command decode and address pointer
   // ----------------------------------------------------------------
   function automatic logic [`ADDR_W-1:0] step(input logic [`ADDR_W-1:0] p,
                                               input logic dec,
                                               input lcd_pkg::mem_sel_t t);
      logic [`ADDR_W-1:0] lim;
      lim = (t == lcd_pkg::MEM_GLYPH) ? 5'h1f : 5'h0f;
      if (dec) begin
         step = (p == 5'h00) ? lim : p - 5'h01;
      end else begin
         step = (p == lim) ? 5'h00 : p + 5'h01;
      end
   endfunction

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         command_q <= 8'h00;
         ptr_q <= 5'h00;
         target_q <= lcd_pkg::MEM_DISP;
         decrement_q <= 1'b0;
      end else if (wr_cmd) begin
         command_q <= rx_byte;
         if (rx_byte[7:4] == `CMD_SET_DISP_HI) begin
            ptr_q <= {1'b0, rx_byte[3:0]};
            target_q <= lcd_pkg::MEM_DISP;
         end else if (rx_byte[7:5] == `CMD_SET_GLYPH_HI) begin
            ptr_q <= rx_byte[4:0];
            target_q <= lcd_pkg::MEM_GLYPH;
         end else if (rx_byte[7:4] == `CMD_SET_ICON_HI) begin
            ptr_q <= {1'b0, rx_byte[3:0]};
            target_q <= lcd_pkg::MEM_ICON;
         end else if (rx_byte[7:2] == `CMD_MODE_HI) begin
            decrement_q <= rx_byte[`CMD_MODE_DEC_BIT];
         end else if (rx_byte == `CMD_HOME || rx_byte == `CMD_CLEAR) begin
            ptr_q <= 5'h00;
            target_q <= lcd_pkg::MEM_DISP;
         end
      end else if (pend_write_q || pend_read_q) begin
         ptr_q <= step(ptr_q, decrement_q, target_q);
      end
   end

   // ----------------------------------------------------------------
   // Data register and memory transfer
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_write_q <= 1'b0;
         pend_read_q <= 1'b0;
         fetch_q <= 1'b0;
         busy_q <= 3'h0;
      end else begin
         pend_write_q <= wr_data;
         pend_read_q <= rd_mem;
         // Fetch waits one cycle so it sees the pointer and target just updated
         fetch_q <= pend_read_q | (wr_cmd & (rx_byte[7:5] != 3'h0));
         if (wr_cmd) begin
            busy_q <= 3'(`BUSY_CYC);
         end else if (busy_q != 3'h0) begin
            busy_q <= busy_q - 3'h1;
         end
      end
   end

   // Read prefetches the next location so the following frame sees fresh data
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         data_q <= 8'h00;
      end else if (wr_data) begin
         data_q <= rx_byte;
      end else if (fetch_q) begin
         case (target_q)
            lcd_pkg::MEM_GLYPH: data_q <= {3'h0, glyph_mem_q[ptr_q]};
            lcd_pkg::MEM_ICON: data_q <= {3'h0, icon_mem_q[ptr_q[3:0]]};
            default: data_q <= disp_mem_q[ptr_q[3:0]];
         endcase
      end
   end

   // Memories, flip-flop based; clear fills the display with spaces
   always_ff @(posedge ref_clk) begin
      if (wr_cmd && rx_byte == `CMD_CLEAR) begin
         for (int i = 0; i < `DISP_DEPTH; i++) begin
            disp_mem_q[i] <= 8'h20;
         end
      end else if (pend_write_q) begin
         case (target_q)
            lcd_pkg::MEM_GLYPH: glyph_mem_q[ptr_q] <= data_q[4:0];
            lcd_pkg::MEM_ICON: icon_mem_q[ptr_q[3:0]] <= data_q[4:0];
            default: disp_mem_q[ptr_q[3:0]] <= data_q;
         endcase
      end
   end

   assign cursor_char = data_q;

   // ----------------------------------------------------------------
   // Ports: output latch and input sample
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         latch_q <= `OUT_LATCH_RST;
         in_port_q <= 8'h00;
      end else begin
         in_port_q <= in_pins_s;
         if (wr_data) begin
            latch_q <= rx_byte;
         end
      end
   end

   // Open drain: enable pulls low where latch bit is zero
   assign output_pins_oe = ~latch_q[5:0];

   // ----------------------------------------------------------------
   // Key scan and common sequencer
   // ----------------------------------------------------------------
   logic [7:0] div_q;
   logic [2:0] col_q;
   logic [7:0] hit_q;
   logic [4:0] com_q;
   wire logic tick = (div_q == 8'h00);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_q <= 8'h00;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end

   // Columns scanned one per tick; a return line low means a key is down
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         col_q <= 3'h0;
         hit_q <= 8'h00;
         key_q <= 8'h00;
      end else if (tick) begin
         col_q <= col_q + 3'h1;
         hit_q[col_q] <= (key_ret_s != 4'hf);
         if (key_ret_s != 4'hf) begin
            key_q <= {1'b0, col_q, ~key_ret_s};
         end
      end
   end

   assign key_drive_lines = ~(8'h01 << col_q);
   assign key_pressed_flag = (hit_q != 8'h00);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         com_q <= 5'h00;
      end else if (tick) begin
         com_q <= (com_q == 5'(`COM_COUNT - 1)) ? 5'h00 : com_q + 5'h01;
      end
   end

   assign common_index = com_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_cmd_no_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      is_sel(sel, 3'b100) |-> tx_byte == 8'h00) else $error("command readable");
   chk_inport_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      is_sel(sel, 3'b001) |-> tx_byte == in_port_q) else $error("bad input read");
   chk_key_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      is_sel(sel, 3'b011) |-> tx_byte == key_q) else $error("bad key read");
   chk_busy_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      is_sel(sel, 3'b101) |-> tx_byte[4:0] == ptr_q) else $error("bad pointer read");
   chk_data_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_data |=> data_q == $past(rx_byte) && latch_q == $past(rx_byte))
      else $error("write lost");
   sequence write_seq;
      wr_data ##1 pend_write_q;
   endsequence
   chk_ptr_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
      write_seq |=> ptr_q != $past(ptr_q)) else $error("pointer stuck");
   chk_addr_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_cmd && rx_byte[7:4] == `CMD_SET_DISP_HI |=> ptr_q == {1'b0, $past(rx_byte[3:0])})
      else $error("address not loaded");
   chk_busy_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_cmd |=> busy [*3]) else $error("busy missing");
   chk_com_wrap: assert property (@(posedge ref_clk) disable iff (!rst_n)
      com_q < 5'(`COM_COUNT)) else $error("common out of range");
   chk_key_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
      hit_q == 8'h00 |-> !key_pressed_flag) else $error("false key flag");

endmodule

// file: lcd_host_model.sv
/*
 Host side of the serial link: one 8-bit frame per call, MSB first.
 Assumes the bench sets the selection pins before calling xfer.
*/
`timescale 1ns/100ps

module lcd_host_model #(
   parameter int HALF_NS = 32
) (
   output logic serial_clock,
   output logic chip_select_n,
   output logic serial_data_in,
   input wire logic serial_data_out,
   input wire logic serial_data_oe
);
   logic host_oe = 1'b0;
   logic host_d = 1'b0;
   logic last_q = 1'b0;

   initial begin
      serial_clock = 1'b1;
      chip_select_n = 1'b1;
   end

   // --------------------------------------------------------------
   // Shared data line
   // --------------------------------------------------------------
   // No pull on the line, so a released line shows the inverse of its last level
   always_comb begin
      if (serial_data_oe)
         serial_data_in = serial_data_out;
      else if (host_oe)
         serial_data_in = host_d;
      else
         serial_data_in = ~last_q;
   end

   always @(posedge serial_clock) last_q <= serial_data_in;

   // --------------------------------------------------------------
   // Frame transfer
   // --------------------------------------------------------------
   // Clock stands high outside frames; 64 ns period runs at 15.625 MHz, above the 1 MHz SHIFT_MAX_KHZ
   task automatic xfer(input logic rd_mode, input logic [7:0] wr, output logic [7:0] rd);
      int i;
      host_oe = ~rd_mode;
      host_d = wr[7];
      chip_select_n = 1'b0;
      #(2 * HALF_NS);
      for (i = 7; i >= 0; i--) begin
         serial_clock = 1'b0;
         host_d = wr[i];
         #HALF_NS;
         rd[i] = serial_data_in;
         serial_clock = 1'b1;
         #HALF_NS;
      end
      #HALF_NS;
      chip_select_n = 1'b1;
      host_oe = 1'b0;
      #(4 * HALF_NS);
   endtask
endmodule

// file: testbench.sv
/*
 Self-checking bench for the host register logic against array memory models.
 Assumes the design files and the host link model are compiled first.
*/
`timescale 1ns/100ps

module testbench;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   lcd_pkg::select_t sel = '0;
   logic [3:0] key_return_lines = 4'hf;
   logic [7:0] input_pins = 8'h00;
   wire serial_clock;
   wire chip_select_n;
   wire serial_data_in;
   wire serial_data_out;
   wire serial_data_oe;
   logic [7:0] key_drive_lines;
   logic [5:0] output_pins_oe;
   logic key_pressed_flag;
   logic [4:0] common_index;
   logic [7:0] cursor_char;
   int fail_count = 0;
   int compares = 0;
   logic [7:0] disp_m [16];
   logic [7:0] glyph_m [32];
   logic [7:0] icon_m [16];
   int ptr = 0;
   int tgt = 0;
   bit dec = 0;
   bit key_on = 0;
   logic [2:0] key_col = 3'h3;
   logic [7:0] rd;
   int i;

   always #2 ref_clk = ~ref_clk;

   lcd_host_regs i_lcd_host_regs (
      .ref_clk(ref_clk), .rst_n(rst_n),
      .test_select(sel.test_sel), .register_select(sel.reg_sel),
      .direction_select(sel.dir_sel), .chip_select_n(chip_select_n),
      .serial_clock(serial_clock), .serial_data_in(serial_data_in),
      .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
      .key_return_lines(key_return_lines), .key_drive_lines(key_drive_lines),
      .input_pins(input_pins), .output_pins_oe(output_pins_oe),
      .key_pressed_flag(key_pressed_flag), .common_index(common_index),
      .cursor_char(cursor_char)
   );

   lcd_host_model i_lcd_host_model (
      .serial_clock(serial_clock), .chip_select_n(chip_select_n),
      .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
      .serial_data_oe(serial_data_oe)
   );

   // --------------------------------------------------------------
   // Compare, report and ending
   // --------------------------------------------------------------
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic summarize;
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // --------------------------------------------------------------
   // Pin models and watchers
   // --------------------------------------------------------------
   // One key at key_col, row 0: return line 0 pulled low while its column drives
   always @(negedge ref_clk)
      key_return_lines <= (key_on && key_drive_lines[key_col] === 1'b0) ? 4'he : 4'hf;

   always @(negedge ref_clk) if (rst_n) chk1(common_index < 5'd18, 1'b1);

   // --------------------------------------------------------------
   // Host accesses
   // --------------------------------------------------------------
   // Selects settle past the two-flop sync before the frame starts
   task automatic access(input logic [2:0] s, input logic [7:0] wr, output logic [7:0] v);
      @(negedge ref_clk);
      sel = s;
      repeat (4) @(negedge ref_clk);
      i_lcd_host_model.xfer(s[0], wr, v);
   endtask

   task automatic wait_ready;
      int n;
      logic [7:0] st;
      n = 0;
      do begin
         access(3'b101, 8'h00, st);
         n++;
      end while (st[7] !== 1'b0 && n < 40);
      if (st[7] !== 1'b0) begin
         fail_count++;
         summarize();
      end
   endtask

   task automatic put(input logic [2:0] s, input logic [7:0] v);
      logic [7:0] d;
      access(s, v, d);
      wait_ready();
   endtask

   task automatic step_ptr;
      ptr = (dec ? ptr - 1 : ptr + 1) & ((tgt == 1) ? 31 : 15);
   endtask

   task automatic chk_ptr;
      logic [7:0] st;
      access(3'b101, 8'h00, st);
      chk8(st, {3'b000, ptr[4:0]});
   endtask

   // Address commands: display 1000aaaa, glyph 010aaaaa, icon 0011aaaa
   task automatic set_addr(input int t, input int a);
      logic [7:0] c;
      c = (t == 0) ? 8'h80 : ((t == 1) ? 8'h40 : 8'h30);
      tgt = t;
      ptr = a;
      put(3'b000, c | 8'(a));
   endtask

   task automatic data_write(input logic [7:0] v);
      put(3'b010, v);
      if (tgt == 0)
         disp_m[ptr] = v;
      else if (tgt == 1)
         glyph_m[ptr] = v & 8'h1f;
      else
         icon_m[ptr] = v & 8'h1f;
      step_ptr();
      chk8({2'b00, output_pins_oe}, {2'b00, ~v[5:0]});
      chk8(cursor_char, v);
   endtask

   task automatic data_read;
      logic [7:0] v;
      logic [7:0] e;
      e = (tgt == 0) ? disp_m[ptr] : ((tgt == 1) ? glyph_m[ptr] : icon_m[ptr]);
      access(3'b111, 8'h00, v);
      chk8(v, e);
      step_ptr();
      wait_ready();
   endtask

   task automatic wait_flag(input logic v);
      int n;
      n = 0;
      while (key_pressed_flag !== v && n < 20000) begin
         @(negedge ref_clk);
         n++;
      end
      if (n >= 20000) begin
         fail_count++;
         summarize();
      end
   endtask

   // --------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------
   initial begin
      void'($urandom(46815));
      repeat (5) @(negedge ref_clk);
      // Reset values are looked at while reset still holds; the scan starts on release
      chk1(key_pressed_flag, 1'b0);
      chk8({2'b00, output_pins_oe}, 8'h00);
      chk8(key_drive_lines, 8'hfe);
      rst_n = 1'b1;
      repeat (2) @(negedge ref_clk);
      // Display writes step the pointer up, then read back in order
      set_addr(0, 3);
      chk_ptr();
      for (i = 0; i < 4; i++) data_write(8'($urandom));
      chk_ptr();
      set_addr(0, 3);
      for (i = 0; i < 4; i++) data_read();
      // Home command, and the command register gives nothing back
      put(3'b000, 8'h02);
      ptr = 0;
      chk_ptr();
      access(3'b100, 8'h00, rd);
      chk8(rd, 8'h00);
      // Top glyph entry: pointer wraps, data narrowed to five bits
      set_addr(1, 31);
      data_write(8'($urandom) | 8'he0);
      chk_ptr();
      set_addr(1, 31);
      data_read();
      // Decrement mode on the display memory
      put(3'b000, 8'h07);
      dec = 1;
      set_addr(0, 9);
      data_write(8'($urandom));
      data_write(8'($urandom));
      chk_ptr();
      set_addr(0, 9);
      data_read();
      data_read();
      // Icon memory, still decrementing: pointer wraps from zero to fifteen
      set_addr(2, 0);
      data_write(8'($urandom));
      chk_ptr();
      set_addr(2, 0);
      data_read();
      // Input port sampled into its register
      for (i = 0; i < 3; i++) begin
         @(negedge ref_clk);
         input_pins = 8'($urandom);
         access(3'b001, 8'h00, rd);
         chk8(rd, input_pins);
      end
      // Key press raises the request and loads the key register
      key_col = 3'($urandom % 8);
      key_on = 1;
      wait_flag(1'b1);
      chk1(key_pressed_flag, 1'b1);
      access(3'b011, 8'h00, rd);
      chk8(rd, {1'b0, key_col, 4'h1});
      key_on = 0;
      wait_flag(1'b0);
      chk1(key_pressed_flag, 1'b0);
      summarize();
   end
endmodule
